// ---- hdl/dma_arb_pkg.sv ----
package dma_arb_pkg;

    // Channel count and widths.
    localparam int NUM_CH = 4;
    localparam int PRIO_W = 3;
    localparam int CNT_W = 16;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] CPU_PRIO_OFS = 8'h00;
    localparam logic [7:0] BUS_CTRL_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] ARB_STAT_OFS = 8'h0C;
    localparam logic [7:0] CH_BASE_OFS = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] MODE_SUB = 8'h00;
    localparam logic [7:0] ADDR_CTL_SUB = 8'h04;
    localparam logic [7:0] COUNT_SUB = 8'h08;

    // Field positions in the CPU priority control register.
    localparam int CPU_LVL_LSB = 0;
    localparam int PCE_BIT = 8;
    // Field positions in bus control register two.
    localparam int ALT_SEL_BIT = 0;
    // Field positions in each channel mode register.
    localparam int TE_BIT = 0;
    localparam int TEF_BIT = 1;
    localparam int TEIE_BIT = 2;
    localparam int ESF_BIT = 3;
    localparam int ESCAPE_END_IRQ_ENABLE_BIT = 4;
    localparam int SZE_BIT = 5;
    localparam int PEND_BIT = 6;
    localparam int BLK_BIT = 7;
    localparam int RPT_BIT = 8;
    localparam int BURST_BIT = 9;
    localparam int DUAL_BIT = 10;
    localparam int CH_LVL_LSB = 12;
    localparam int ASZ_LSB = 16;
    localparam int BSZ_LSB = 24;
    // Field positions in each address control register.
    localparam int RPE_BIT = 0;
    localparam int SAE_BIT = 1;
    localparam int DAE_BIT = 2;

    // Reset values and bus answers.
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    // Bus ownership decided by the arbiter.
    typedef enum logic [1:0] {
        OWN_CPU = 2'b00,
        OWN_DMA_RD = 2'b01,
        OWN_DMA_WR = 2'b10,
        OWN_EXT = 2'b11
    } owner_e;

    // Transfer events from the address and count datapath, per channel.
    typedef struct packed {
        logic xfer_done;
        logic next_req;
        logic src_ovf;
        logic dst_ovf;
        logic rpt_done;
        logic internal;
    } ch_event_s;

    // Requests from the other bus users.
    typedef struct packed {
        logic cpu_req;
        logic peer_req;
        logic refresh_req;
        logic ext_release_req;
    } bus_req_s;

endpackage : dma_arb_pkg

// ---- hdl/dma_prio_arb_irq.sv ----
// Overview of operation
// - Per-channel and CPU three-bit priority levels.
// - Higher CPU level masks channel request.
// - Equal or higher channel level gets accepted.
// - Masked request held; enable clear discards it.
// - Disabled priority control: CPU lowest.
// - Read and write of transfer stay together.
// - Block or burst: DMA holds bus consecutively.
// - Channel change or cycle steal alternates.
// - Alternate select set: bus alternates.
// - External release inserted between transfers, even in burst.
// - Release after write; internal access concurrent.
// - Per-channel end and escape interrupt outputs.
// - End interrupt is flag AND enable.
// - Escape interrupt is flag AND enable.
// - Four escape causes share one output.
// - Separate enables per cause.
// - End flag set when count reaches zero with end enable set.
// - Escape flag set by enabled cause.
// - Size error: remaining count below size.
// - Repeat end after full repeat size.
// - Overflow past extended repeat area.
module dma_prio_arb_irq
    import dma_arb_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Channel requests and datapath events.
    input wire logic [NUM_CH-1:0] ch_req,
    input wire dma_arb_pkg::ch_event_s [NUM_CH-1:0] ch_ev,
    // Other bus masters and the exception priority level.
    input wire dma_arb_pkg::bus_req_s bus_req,
    input wire logic [PRIO_W-1:0] cpu_exc_level,
    // Bus grant and accepted channel.
    output dma_arb_pkg::owner_e bus_owner,
    output logic [NUM_CH-1:0] ch_grant,
    output logic ext_release_grant,
    // Interrupt requests.
    output logic [NUM_CH-1:0] transfer_end_irq_ch,
    output logic [NUM_CH-1:0] escape_end_irq_ch
);
    import dma_arb_pkg::*;

    // Priority control register and bus control register two.
    logic [PRIO_W-1:0] cpu_priority_level_q;
    logic priority_control_enable_q;
    logic internal_bus_alternate_select_q;
    // Per-channel mode, address control and transfer count.
    logic [31:0] channel_mode_reg_q [NUM_CH];
    logic [2:0] channel_address_control_reg_q [NUM_CH];
    logic [CNT_W-1:0] transfer_count_q [NUM_CH];
    // Arbiter state.
    owner_e owner_q;
    logic [1:0] cur_ch_q;
    logic last_dma_q;

    // Decodes the channel index of a channel register address.
    function automatic logic [1:0] ch_of(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - CH_BASE_OFS;
        return rel[5:4];
    endfunction : ch_of

    // True when the address hits a channel register block.
    function automatic logic is_ch(input logic [7:0] a);
        return (a >= CH_BASE_OFS) && (a < CH_BASE_OFS + 4 * CH_STRIDE);
    endfunction : is_ch

    // Write path: both address and data are latched, in either order.
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    wire logic do_write = aw_hold_q && w_hold_q && !s_bvalid;
    wire logic [7:0] w_sub = aw_q - CH_BASE_OFS;
    wire logic [1:0] w_ch = ch_of(aw_q);
    wire logic w_in_ch = is_ch(aw_q);
    wire logic w_mapped = w_in_ch || aw_q == CPU_PRIO_OFS
        || aw_q == BUS_CTRL_OFS || aw_q == STATUS_OFS
        || aw_q == ARB_STAT_OFS;
    assign s_awready = !aw_hold_q;
    assign s_wready = !w_hold_q;

    // Address and data capture, and write response handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= ZERO_WORD;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_hold_q <= 1'b1;
                aw_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_hold_q <= 1'b1;
                w_q <= s_wdata;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= w_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Global control registers; the CPU level tracks exception priority.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_priority_level_q <= 3'h0;
            priority_control_enable_q <= 1'b0;
            internal_bus_alternate_select_q <= 1'b0;
        end else begin
            cpu_priority_level_q <= cpu_exc_level;
            if (do_write && aw_q == CPU_PRIO_OFS) begin
                priority_control_enable_q <= w_q[PCE_BIT];
            end
            if (do_write && aw_q == BUS_CTRL_OFS) begin
                internal_bus_alternate_select_q <= w_q[ALT_SEL_BIT];
            end
        end
    end

    // Per-channel effective request gating and interrupt generation.
    logic [NUM_CH-1:0] ch_ok;
    logic [NUM_CH-1:0] ch_pending;
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            wire logic [31:0] md = channel_mode_reg_q[g];
            wire logic [2:0] ac = channel_address_control_reg_q[g];
            wire logic [CNT_W-1:0] cnt = transfer_count_q[g];
            wire logic [7:0] asz = md[ASZ_LSB +: 8];
            wire logic [7:0] bsz = md[BSZ_LSB +: 8];
            wire logic [PRIO_W-1:0] lvl = md[CH_LVL_LSB +: PRIO_W];
            wire logic [PRIO_W-1:0] cpu_eff =
                priority_control_enable_q ? cpu_priority_level_q : 3'h0;
            // mask when CPU outranks, accept when equal or above
            assign ch_ok[g] = lvl >= cpu_eff;
            wire logic wr_hit = do_write && w_in_ch && w_ch == g;
            wire logic wr_mode = wr_hit && w_sub[3:0] == MODE_SUB[3:0];
            wire logic ev_step = ch_ev[g].xfer_done && ch_grant[g];
            // size error against access or block size
            wire logic size_err = md[SZE_BIT] && ch_ev[g].next_req
                && (cnt < {8'h00, (md[BLK_BIT] ? bsz : asz)});
            // repeat end when next request follows a full repeat
            wire logic rpt_end = ac[RPE_BIT] && md[RPT_BIT]
                && ch_ev[g].rpt_done && ch_ev[g].next_req;
            wire logic ovf = (ac[SAE_BIT] && ch_ev[g].src_ovf)
                || (ac[DAE_BIT] && ch_ev[g].dst_ovf);
            // any enabled cause raises the escape flag
            wire logic esc_set = md[TE_BIT] && (size_err || rpt_end || ovf);
            // count reaching zero with end enable set
            wire logic end_set = ev_step && cnt == 16'h0001
                && md[TEIE_BIT];
            wire logic zero_hit = ev_step && cnt == 16'h0001;
            assign ch_pending[g] = md[PEND_BIT];
            // end output from flag and enable
            assign transfer_end_irq_ch[g] = md[TEF_BIT] && md[TEIE_BIT];
            // shared escape output from flag and enable
            assign escape_end_irq_ch[g] = md[ESF_BIT] && md[ESCAPE_END_IRQ_ENABLE_BIT];

            // Mode register with hardware set winning over software clear.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    channel_mode_reg_q[g] <= ZERO_WORD;
                    channel_address_control_reg_q[g] <= 3'h0;
                    transfer_count_q[g] <= CNT_ZERO;
                end else begin
                    // software writes clear flags or restart
                    if (wr_mode) begin
                        channel_mode_reg_q[g] <= w_q;
                        channel_mode_reg_q[g][PEND_BIT] <=
                            w_q[TE_BIT] && md[PEND_BIT];
                    end else if (md[TE_BIT]) begin
                        channel_mode_reg_q[g][PEND_BIT] <=
                            (md[PEND_BIT] || ch_req[g]) && !ch_grant[g];
                    end
                    if (wr_hit && w_sub[3:0] == ADDR_CTL_SUB[3:0]) begin
                        channel_address_control_reg_q[g] <= w_q[2:0];
                    end
                    if (wr_hit && w_sub[3:0] == COUNT_SUB[3:0]) begin
                        transfer_count_q[g] <= w_q[CNT_W-1:0];
                    end else if (ev_step && cnt != CNT_ZERO) begin
                        transfer_count_q[g] <= cnt - 16'h0001;
                    end
                    if (end_set) begin
                        channel_mode_reg_q[g][TEF_BIT] <= 1'b1;
                    end
                    if (esc_set) begin
                        channel_mode_reg_q[g][ESF_BIT] <= 1'b1;
                    end
                    if (zero_hit || esc_set) begin
                        channel_mode_reg_q[g][TE_BIT] <= 1'b0;
                        channel_mode_reg_q[g][PEND_BIT] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Lowest accepted pending channel gets the next transfer.
    logic [NUM_CH-1:0] ready_ch;
    assign ready_ch = ch_pending & ch_ok;
    wire logic any_ready = |ready_ch;
    wire logic [1:0] pick = ready_ch[0] ? 2'd0 : ready_ch[1] ? 2'd1
        : ready_ch[2] ? 2'd2 : 2'd3;
    wire logic [31:0] cur_md = channel_mode_reg_q[cur_ch_q];
    wire logic cur_burst = cur_md[BLK_BIT] || cur_md[BURST_BIT];
    wire logic others = bus_req.cpu_req || bus_req.peer_req
        || bus_req.refresh_req;
    // alternate after a DMA transfer unless burst holds the bus
    wire logic yield = last_dma_q && others
        && (internal_bus_alternate_select_q || !cur_burst
            || pick != cur_ch_q);
    wire logic internal_now = ch_ev[cur_ch_q].internal;

    // Bus owner sequencing: read then write, never split.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            owner_q <= OWN_CPU;
            cur_ch_q <= 2'd0;
            last_dma_q <= 1'b0;
        end else begin
            unique case (owner_q)
                OWN_DMA_RD: begin
                    owner_q <= OWN_DMA_WR;
                end
                OWN_DMA_WR, OWN_CPU, OWN_EXT: begin
                    // external release never between read and write
                    if (bus_req.ext_release_req && !internal_now) begin
                        owner_q <= OWN_EXT;
                        last_dma_q <= 1'b0;
                    end else if (any_ready && !yield) begin
                        // burst keeps DMA on the bus
                        owner_q <= OWN_DMA_RD;
                        cur_ch_q <= pick;
                        last_dma_q <= 1'b1;
                    end else begin
                        owner_q <= OWN_CPU;
                        last_dma_q <= 1'b0;
                    end
                end
            endcase
        end
    end
    assign bus_owner = owner_q;
    // internal access may run beside the external release
    assign ext_release_grant = owner_q == OWN_EXT
        || (bus_req.ext_release_req && internal_now
            && owner_q != OWN_CPU);
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_grant
            assign ch_grant[g] = owner_q == OWN_DMA_WR && cur_ch_q == g;
        end
    endgenerate

    // Read path: one read at a time, answered the next cycle.
    wire logic [1:0] r_ch = ch_of(s_araddr);
    wire logic [7:0] r_sub = s_araddr - CH_BASE_OFS;
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_val = ZERO_WORD;
        rd_ok = 1'b1;
        if (s_araddr == CPU_PRIO_OFS) begin
            rd_val[CPU_LVL_LSB +: PRIO_W] = cpu_priority_level_q;
            rd_val[PCE_BIT] = priority_control_enable_q;
        end else if (s_araddr == BUS_CTRL_OFS) begin
            rd_val[ALT_SEL_BIT] = internal_bus_alternate_select_q;
        end else if (s_araddr == STATUS_OFS) begin
            rd_val = {24'h00_0000, escape_end_irq_ch, transfer_end_irq_ch};
        end else if (s_araddr == ARB_STAT_OFS) begin
            rd_val = {28'h000_0000, cur_ch_q, owner_q};
        end else if (is_ch(s_araddr) && r_sub[3:0] == MODE_SUB[3:0]) begin
            rd_val = channel_mode_reg_q[r_ch];
        end else if (is_ch(s_araddr) && r_sub[3:0] == ADDR_CTL_SUB[3:0])
        begin
            rd_val = {29'h0000_0000, channel_address_control_reg_q[r_ch]};
        end else if (is_ch(s_araddr) && r_sub[3:0] == COUNT_SUB[3:0]) begin
            rd_val = {16'h0000, transfer_count_q[r_ch]};
        end else begin
            rd_ok = 1'b0;
        end
    end
    assign s_arready = !s_rvalid;

    // Read data register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= ZERO_WORD;
            s_rresp <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_val;
            s_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // Checks on the arbiter and interrupt outputs.
    property p_rd_wr_pair;
        @(posedge aclk) disable iff (!aresetn)
        owner_q == OWN_DMA_RD |=> owner_q == OWN_DMA_WR;
    endproperty
    a_rd_wr_pair: assert property (p_rd_wr_pair)
        else $error("DMA read not followed by write");
    property p_end_irq;
        @(posedge aclk) disable iff (!aresetn)
        transfer_end_irq_ch[0] == (channel_mode_reg_q[0][TEF_BIT]
            && channel_mode_reg_q[0][TEIE_BIT]);
    endproperty
    a_end_irq: assert property (p_end_irq)
        else $error("End interrupt mismatch");
    property p_esc_irq;
        @(posedge aclk) disable iff (!aresetn)
        escape_end_irq_ch[1] == (channel_mode_reg_q[1][ESF_BIT]
            && channel_mode_reg_q[1][ESCAPE_END_IRQ_ENABLE_BIT]);
    endproperty
    a_esc_irq: assert property (p_esc_irq)
        else $error("Escape interrupt mismatch");
    property p_sticky;
        @(posedge aclk) disable iff (!aresetn)
        $rose(channel_mode_reg_q[0][TEF_BIT]) && !do_write
            |=> channel_mode_reg_q[0][TEF_BIT];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("End flag dropped");
    property p_mask;
        @(posedge aclk) disable iff (!aresetn)
        owner_q == OWN_DMA_RD |-> cur_ch_q == 2'd0 && $past(ready_ch[0])
            || cur_ch_q == 2'd1 && $past(ready_ch[1]) || cur_ch_q == 2'd2
            && $past(ready_ch[2]) || cur_ch_q == 2'd3 && $past(ready_ch[3]);
    endproperty
    a_mask: assert property (p_mask)
        else $error("Masked channel started");
    property p_lowest;
        @(posedge aclk) disable iff (!aresetn)
        !priority_control_enable_q |-> &ch_ok;
    endproperty
    a_lowest: assert property (p_lowest)
        else $error("Request masked with control off");
    property p_zero_end;
        @(posedge aclk) disable iff (!aresetn)
        ch_grant[0] && ch_ev[0].xfer_done && transfer_count_q[0] == 16'h0001
            && channel_mode_reg_q[0][TEIE_BIT] && !do_write
            |=> transfer_end_irq_ch[0] ##0 transfer_count_q[0] == CNT_ZERO;
    endproperty
    a_zero_end: assert property (p_zero_end)
        else $error("End flag not set at zero count");
    property p_alt;
        @(posedge aclk) disable iff (!aresetn)
        internal_bus_alternate_select_q && owner_q == OWN_DMA_WR
            && bus_req.cpu_req && !bus_req.ext_release_req
            |=> owner_q != OWN_DMA_RD;
    endproperty
    a_alt: assert property (p_alt)
        else $error("No alternation with select set");
    c_write: cover property (@(posedge aclk) disable iff (!aresetn)
        owner_q == OWN_DMA_WR);
    c_ext: cover property (@(posedge aclk) disable iff (!aresetn)
        owner_q == OWN_EXT);
    c_esc: cover property (@(posedge aclk) disable iff (!aresetn)
        |escape_end_irq_ch);

endmodule : dma_prio_arb_irq

// ---- sim/bus_master_model.sv ----
module bus_master_model
    import dma_arb_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Control from the bench and grant from the block.
    input wire logic want_release,
    input wire logic ext_release_grant,
    // Requests towards the block.
    output dma_arb_pkg::bus_req_s bus_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rel_q; // Release request, held until it is served.
    // Holding the request mimics a real release requester, which never
    // withdraws on its own and so would hang if the block starved it.
    // release held until grant
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rel_q <= 1'b0;
        end else if (rel_q && ext_release_grant) begin
            rel_q <= 1'b0; // Served, so the requester withdraws.
        end else if (want_release) begin
            rel_q <= 1'b1;
        end
    end
    // The CPU always wants the bus, so the DMA must win it on merit.
    assign bus_req = '{cpu_req: 1'b1, peer_req: 1'b0, refresh_req: 1'b0,
                       ext_release_req: rel_q};
endmodule : bus_master_model

// ---- sim/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_arb_pkg::*;
    typedef struct {
        int ch;
        logic [31:0] mode, actl, cnt;
        logic [5:0] ev;
        logic e_end, e_esc;
    } row_s;
    // Event order is xfer_done, next_req, src_ovf, dst_ovf, rpt_done.
    row_s rows [7] = '{
        '{0, 32'h0000_0005, 32'h0000_0000, 32'h0000_0001, 6'h20, 1, 0},
        '{1, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 6'h20, 0, 0},
        '{2, 32'h0000_0011, 32'h0000_0002, 32'h0000_0000, 6'h08, 0, 1},
        '{3, 32'h0000_0011, 32'h0000_0004, 32'h0000_0000, 6'h04, 0, 1},
        '{0, 32'h0000_0011, 32'h0000_0000, 32'h0000_0000, 6'h04, 0, 0},
        '{1, 32'h0000_0111, 32'h0000_0001, 32'h0000_0000, 6'h12, 0, 1},
        '{2, 32'h0004_0031, 32'h0000_0000, 32'h0000_0002, 6'h10, 0, 1}};
    logic aclk = 0, aresetn = 0, want_release = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, q;
    logic [3:0] wstrb = 4'hF, ch_req = 0, ch_grant, te_irq, es_irq;
    logic awready, wready, bvalid, arready, rvalid, ext_release_grant;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] cpu_exc_level = 3'h5;
    ch_event_s [NUM_CH-1:0] ch_ev = '0;
    bus_req_s bus_req;
    owner_e bus_owner;
    int n_errors = 0, samples_checked = 0, cyc = 0, i;
    logic granted = 0, prev_rd = 0;
    always #20 aclk = ~aclk; // 25 MHz.
    bus_master_model bus_master_model_i (.aclk(aclk), .aresetn(aresetn),
        .want_release(want_release), .ext_release_grant(ext_release_grant),
        .bus_req(bus_req));
    dma_prio_arb_irq dma_prio_arb_irq_i (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
        .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
        .s_rvalid(rvalid), .s_rready(rready), .ch_req(ch_req),
        .ch_ev(ch_ev), .bus_req(bus_req), .cpu_exc_level(cpu_exc_level),
        .bus_owner(bus_owner), .ch_grant(ch_grant),
        .ext_release_grant(ext_release_grant),
        .transfer_end_irq_ch(te_irq), .escape_end_irq_ch(es_irq));
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    // One AXI4-Lite write or read; each channel is held until taken.
    task automatic axi(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge aclk);
        if (w) begin
            awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        end else begin
            araddr <= a; arvalid <= 1; rready <= 1;
        end
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (arvalid && arready) arvalid <= 0;
            if (w && bready && bvalid) begin
                bready <= 0; rs = bresp; break;
            end
            if (!w && rready && rvalid) begin
                rready <= 0; q = rdata; rs = rresp; break;
            end
        end
    endtask : axi
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Watchdog, grant sticky flag and read/write pairing monitor.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
        if (ch_grant[0] === 1'b1) granted = 1;
        if (prev_rd) chk("owner after read", OWN_DMA_WR, bus_owner);
        prev_rd = (bus_owner === OWN_DMA_RD);
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        chk("owner at reset", OWN_CPU, bus_owner);
        chk("irqs at reset", 0, {te_irq, es_irq});
        axi(0, 8'hF0, 0);
        chk("unmapped resp", RESP_SLVERR, rs);
        // Interrupt rows: set up, fire one event, check, then clear.
        foreach (rows[k]) begin
            axi(1, CH_BASE_OFS + CH_STRIDE * 8'(rows[k].ch) + COUNT_SUB,
                rows[k].cnt);
            axi(1, CH_BASE_OFS + CH_STRIDE * 8'(rows[k].ch) + ADDR_CTL_SUB,
                rows[k].actl);
            axi(1, CH_BASE_OFS + CH_STRIDE * 8'(rows[k].ch), rows[k].mode);
            // An end-of-count event only counts while the channel holds
            // the bus, so the channel requests for the whole window.
            ch_ev[rows[k].ch] <= ch_event_s'(rows[k].ev);
            ch_req[rows[k].ch] <= 1'b1;
            repeat (6) @(posedge aclk);
            ch_ev[rows[k].ch] <= '0;
            ch_req <= 4'h0;
            chk("end irq", rows[k].e_end, te_irq[rows[k].ch]);
            chk("esc irq", rows[k].e_esc, es_irq[rows[k].ch]);
            axi(0, STATUS_OFS, 0);
            chk("status", 32'(rows[k].e_esc) << (4 + rows[k].ch)
                | 32'(rows[k].e_end) << rows[k].ch, q);
            axi(1, CH_BASE_OFS + CH_STRIDE * 8'(rows[k].ch), 0);
            repeat (2) @(posedge aclk);
            chk("irqs cleared", 0, {te_irq, es_irq});
        end
        // CPU level 5 above channel level 3 masks the request.
        axi(1, CPU_PRIO_OFS, 32'h0000_0100);
        axi(1, CH_BASE_OFS, 32'h0000_3001);
        ch_req <= 4'h1;
        repeat (10) @(posedge aclk);
        granted = 0;
        repeat (10) @(posedge aclk);
        chk("masked grant", 0, granted);
        axi(0, CH_BASE_OFS, 0);
        chk("pending held", 1, q[PEND_BIT]);
        axi(1, CH_BASE_OFS, 32'h0000_3000);
        axi(0, CH_BASE_OFS, 0);
        chk("pending dropped", 0, q[PEND_BIT]);
        // Burst mode this time, so the channel keeps the bus.
        axi(1, CH_BASE_OFS, 32'h0000_3201);
        cpu_exc_level <= 3'h3;
        granted = 0;
        for (i = 0; i < 50 && !granted; i++) @(posedge aclk);
        chk("equal level grant", 1, granted);
        // Burst mode: the CPU never gets a cycle between transfers.
        repeat (6) begin
            @(posedge aclk);
            chk("burst holds bus", 0, bus_owner === OWN_CPU);
        end
        want_release <= 1;
        @(posedge aclk);
        want_release <= 0;
        for (i = 0; i < 50 && ext_release_grant !== 1'b1; i++)
            @(posedge aclk);
        chk("release in burst", 1, ext_release_grant);
        // Alternate select set: the CPU must get a turn even in burst.
        axi(1, BUS_CTRL_OFS, 32'h0000_0001);
        for (i = 0; i < 20 && bus_owner !== OWN_CPU; i++) @(posedge aclk);
        chk("alternation", OWN_CPU, bus_owner);
        // Control off: CPU is lowest even at level 7.
        ch_req <= 4'h0;
        axi(1, CPU_PRIO_OFS, 0);
        cpu_exc_level <= 3'h7;
        axi(1, CH_BASE_OFS, 32'h0000_0001);
        axi(0, CPU_PRIO_OFS, 0);
        chk("cpu level", 7, q[CPU_LVL_LSB +: PRIO_W]);
        ch_req <= 4'h1;
        granted = 0;
        for (i = 0; i < 50 && !granted; i++) @(posedge aclk);
        chk("ctrl off grant", 1, granted);
        conclude();
    end
endmodule : testbench
